// ---- design/wssq_defines.svh ----
`ifndef WSSQ_DEFINES_SVH
`define WSSQ_DEFINES_SVH

// Clock is 10 MHz, 100 ns period
`define WSSQ_CLK_NS        100
// Deglitch bounds (us); the filter sits inside them
`define WSSQ_DEGLITCH_MIN_US 7
`define WSSQ_DEGLITCH_MAX_US 20
`define WSSQ_DEGLITCH_US   12
`define WSSQ_DEGLITCH_CYC  ((`WSSQ_DEGLITCH_US * 1000) / `WSSQ_CLK_NS)
// Regulator and POR release after the wake edge (us)
`define WSSQ_POR_US        20
`define WSSQ_POR_CYC       ((`WSSQ_POR_US * 1000) / `WSSQ_CLK_NS)
// Wake to answering break: 130 min, 160 typ, 210 max (us)
`define WSSQ_WAKE_MIN_US   130
`define WSSQ_WAKE_TYP_US   160
`define WSSQ_WAKE_MAX_US   210
`define WSSQ_WAKE_CYC      ((`WSSQ_WAKE_TYP_US * 1000) / `WSSQ_CLK_NS)
// Sleep opcode wait, at least 4 us, rounded up
`define WSSQ_SLP_US        4
`define WSSQ_SLP_CYC       ((`WSSQ_SLP_US * 1000 + `WSSQ_CLK_NS - 1) / `WSSQ_CLK_NS)
`define WSSQ_SLEEP_OPCODE  2'h3
// Auto-sleep timeout 0.6 s = 600000 us
`define WSSQ_AUTO_SLEEP_ENABLE_US       600000
`define WSSQ_AUTO_SLEEP_ENABLE_CYC      ((`WSSQ_AUTO_SLEEP_ENABLE_US / 100) * (1000 / `WSSQ_CLK_NS) * 100)
// Nonvolatile write busy: 1.8 typ, 1.9 max ms (in us)
`define WSSQ_EEW_TYP_US    1800
`define WSSQ_EEW_MAX_US    1900
`define WSSQ_EEW_CYC       ((`WSSQ_EEW_MAX_US * 1000) / `WSSQ_CLK_NS)
// Soft reset to answering break, at most 30 us
`define WSSQ_SRST_US       30
`define WSSQ_SRST_CYC      ((`WSSQ_SRST_US * 1000) / `WSSQ_CLK_NS)
// Host wake break kept under 60 us
`define WSSQ_HOST_BRK_MAX_US 60
`define WSSQ_HOST_BRK_US   40
`define WSSQ_HOST_BRK_CYC  ((`WSSQ_HOST_BRK_US * 1000) / `WSSQ_CLK_NS)
// Break length = 1.391 bit-times, as 1391/1000
`define WSSQ_BRK_NUM       1391
`define WSSQ_BRK_DEN       1000
// Bit-time in cycles for each speed code
`define WSSQ_BT_SPD0       16'd3460
`define WSSQ_BT_SPD1       16'd1730
`define WSSQ_BT_SPD2       16'd865
`define WSSQ_BT_SPD3       16'd433
// Memory map
`define WSSQ_MEM_BYTES     16
`define WSSQ_ADDR_CFG      4'h0
`define WSSQ_ADDR_TRIM     4'h1
`define WSSQ_ADDR_SEC_LO   4'h2
`define WSSQ_ADDR_SEC_HI   4'hd
`define WSSQ_ADDR_GP_LO    4'he
// Default configuration byte fields
`define WSSQ_CFG_AUTO_SLEEP_ENABLE      2
`define WSSQ_CFG_SPD_LO    3
`define WSSQ_CFG_DAB_LO    6
`define WSSQ_CHAL_BITS     32

`endif

// ---- design/wssq_pkg.sv ----
package wssq_pkg;

	typedef enum logic [6:0] {
		WSSQ_SLEEP  = 7'h01,
		WSSQ_POR    = 7'h02,
		WSSQ_LOAD   = 7'h04,
		WSSQ_WAIT   = 7'h08,
		WSSQ_BREAK  = 7'h10,
		WSSQ_ACTIVE = 7'h20,
		WSSQ_SHUT   = 7'h40
	} wssq_state_type;

	typedef logic [7:0] wssq_byte_type;

endpackage : wssq_pkg

// ---- design/wssq_bus_if.sv ----
`timescale 1ns/1ps
interface wssq_bus_if;
	logic dev_out;
	logic dev_oe;
	logic host_out;
	logic host_oe;
	logic line;

	// Open drain with the host pull-up: low while either end drives
	assign line = !((dev_oe && !dev_out) || (host_oe && !host_out));

	modport device (
		input  line,
		output dev_out,
		output dev_oe
	);
	modport host (
		input  line,
		output host_out,
		output host_oe
	);
endinterface : wssq_bus_if

// ---- design/wssq_deglitch.sv ----
`timescale 1ns/1ps
`include "wssq_defines.svh"
module wssq_deglitch
	import wssq_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	input  wire logic line_raw,
	output logic      line_sync,
	output logic      wake_det
);
	localparam int CNT_W = 12;
	localparam logic [CNT_W-1:0] DG_CYC = CNT_W'(`WSSQ_DEGLITCH_CYC);

	logic             s1_r;
	logic             s2_r;
	logic [CNT_W-1:0] low_cnt_r;
	logic [CNT_W-1:0] low_cnt_nxt;
	logic             wake_r;

	wire reached = (low_cnt_r == DG_CYC);
	assign low_cnt_nxt = s2_r ? '0 : (reached ? low_cnt_r : low_cnt_r + 1'b1);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r      <= 1'b1;
			s2_r      <= 1'b1;
			low_cnt_r <= '0;
			wake_r    <= 1'b0;
		end else if (ce) begin
			s1_r      <= line_raw;
			s2_r      <= s1_r;
			low_cnt_r <= low_cnt_nxt;
			wake_r    <= !s2_r && (low_cnt_r == DG_CYC - 1'b1);
		end
	end

	assign line_sync = s2_r;
	assign wake_det  = wake_r;
endmodule : wssq_deglitch

// ---- design/wssq_device.sv ----
`timescale 1ns/1ps
`include "wssq_defines.svh"
module wssq_device
	import wssq_pkg::*;
#(
	parameter int AUTO_SLEEP_ENABLE_CYC = `WSSQ_AUTO_SLEEP_ENABLE_CYC,
	parameter int EEW_CYC  = `WSSQ_EEW_CYC
)
(
	input  wire logic           clk,
	input  wire logic           rst_n,
	input  wire logic           ce,
	wssq_bus_if.device          bus,
	input  wire wssq_byte_type  mem_data [`WSSQ_MEM_BYTES],
	input  wire logic           sleep_op_valid,
	input  wire logic [1:0]     sleep_op,
	input  wire logic           soft_reset,
	input  wire logic           nv_write_done,
	input  wire logic           chal_done,
	input  wire logic           auto_sleep_enable_clear,
	input  wire logic           auto_sleep_enable_set,
	output logic                awake,
	output logic                regulator_on,
	output logic                logic_rst_n,
	output logic [1:0]          dev_addr,
	output logic [1:0]          bus_speed,
	output logic [15:0]         bit_time,
	output wssq_byte_type       control_reg,
	output wssq_byte_type       status_reg,
	output logic                auto_sleep_enable,
	output logic                nv_busy,
	output logic                hash_start,
	output logic                auth_ready
);
	localparam int W = 24;

	wssq_state_type state_r;
	wssq_state_type state_nxt;
	logic [W-1:0]   tmr_r;
	logic [W-1:0]   seq_r;
	logic [W-1:0]   idle_r;
	logic [W-1:0]   ee_r;
	logic [W-1:0]   hash_r;
	logic           prev_line_r;
	logic           line_s;
	logic           wake_det;
	logic           soft_r;
	wssq_byte_type  ctrl_r;
	wssq_byte_type  stat_r;
	logic           auto_sleep_enable_r;
	logic [15:0]    bt_r;
	logic           drive_r;
	logic           auth_r;
	logic           hstart_r;

	function automatic logic [15:0] bt_of(input logic [1:0] spd);
		unique case (spd)
			2'h0: bt_of = `WSSQ_BT_SPD0;
			2'h1: bt_of = `WSSQ_BT_SPD1;
			2'h2: bt_of = `WSSQ_BT_SPD2;
			2'h3: bt_of = `WSSQ_BT_SPD3;
		endcase
	endfunction : bt_of

	function automatic logic [W-1:0] brk_len(input logic [15:0] bt);
		logic [31:0] p;
		p = 32'(bt) * 32'(`WSSQ_BRK_NUM) / 32'(`WSSQ_BRK_DEN);
		brk_len = p[W-1:0];
	endfunction : brk_len

	wssq_deglitch u_dg (
		.clk       (clk),
		.rst_n     (rst_n),
		.ce        (ce),
		.line_raw  (bus.line),
		.line_sync (line_s),
		.wake_det  (wake_det)
	);

	wire wssq_byte_type cfg = mem_data[`WSSQ_ADDR_CFG];
	wire [1:0] cfg_spd = cfg[`WSSQ_CFG_SPD_LO +: 2];
	wire [1:0] cfg_dab = cfg[`WSSQ_CFG_DAB_LO +: 2];
	wire edge_seen     = (line_s != prev_line_r);
	wire is_sleep_op   = sleep_op_valid && (sleep_op == `WSSQ_SLEEP_OPCODE);
	wire idle_expired  = auto_sleep_enable_r && (idle_r >= W'(AUTO_SLEEP_ENABLE_CYC - 1));
	wire [W-1:0] por_c = W'(`WSSQ_POR_CYC);
	wire [W-1:0] wake_c = W'(`WSSQ_WAKE_CYC);
	wire [W-1:0] srst_c = W'(`WSSQ_SRST_CYC);
	wire [W-1:0] slp_c  = W'(`WSSQ_SLP_CYC);
	wire [W-1:0] brk_c  = brk_len(bt_of(cfg_spd));
	// Soft-reset answer halfway into its window, margin for frame decode
	wire wait_target   = soft_r ? (seq_r >= (srst_c >> 1))
		: (seq_r >= wake_c - 1'b1);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			WSSQ_SLEEP:  if (wake_det) state_nxt = WSSQ_POR;
			WSSQ_POR:    if (seq_r >= por_c) state_nxt = WSSQ_LOAD;
			WSSQ_LOAD:   state_nxt = WSSQ_WAIT;
			WSSQ_WAIT:   if (wait_target) state_nxt = WSSQ_BREAK;
			WSSQ_BREAK:  if (tmr_r >= brk_c - 1'b1) state_nxt = WSSQ_ACTIVE;
			WSSQ_ACTIVE: begin
				if (soft_reset) state_nxt = WSSQ_LOAD;
				else if (is_sleep_op || idle_expired) state_nxt = WSSQ_SHUT;
			end
			WSSQ_SHUT: begin
				// A held opcode must not shorten the wait
				if (seq_r >= slp_c) state_nxt = WSSQ_SLEEP;
			end
			default:     state_nxt = WSSQ_SLEEP;
		endcase
	end

	wire sleeping = (state_r == WSSQ_SLEEP);
	wire entering = (state_nxt != state_r);
	wire is_break = (state_nxt == WSSQ_BREAK);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r     <= WSSQ_SLEEP;
			seq_r       <= '0;
			tmr_r       <= '0;
			soft_r      <= 1'b0;
		end else if (ce) begin
			state_r <= state_nxt;
			// Wake detect lands deglitch time after the edge
			if (state_r == WSSQ_SLEEP && wake_det)
				seq_r <= W'(`WSSQ_DEGLITCH_CYC);
			else if (state_r == WSSQ_ACTIVE && soft_reset)
				seq_r <= '0;
			else if (entering && state_nxt == WSSQ_SHUT)
				seq_r <= '0;
			else
				seq_r <= seq_r + 1'b1;
			tmr_r  <= (is_break && state_r != WSSQ_BREAK) ? '0 : tmr_r + 1'b1;
			if (state_r == WSSQ_ACTIVE && soft_reset)
				soft_r <= 1'b1;
			else if (state_r == WSSQ_SLEEP)
				soft_r <= 1'b0;
		end
	end

	// Configuration copied on wake and soft reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= 8'h00;
			stat_r <= 8'h00;
			auto_sleep_enable_r <= 1'b1;
			bt_r   <= `WSSQ_BT_SPD0;
		end else if (ce) begin
			if (state_r == WSSQ_LOAD) begin
				ctrl_r <= cfg;
				stat_r <= cfg;
				auto_sleep_enable_r <= 1'b1;
				bt_r   <= bt_of(cfg_spd);
			end else if (auto_sleep_enable_set)
				auto_sleep_enable_r <= 1'b1;
			else if (auto_sleep_enable_clear)
				auto_sleep_enable_r <= 1'b0;
		end
	end

	// Inactivity timer: any edge restarts it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_line_r <= 1'b1;
			idle_r      <= '0;
		end else if (ce) begin
			prev_line_r <= line_s;
			if (edge_seen || state_r != WSSQ_ACTIVE)
				idle_r <= '0;
			else
				idle_r <= idle_r + 1'b1;
		end
	end

	// Nonvolatile write busy and hash timing
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ee_r     <= '0;
			hash_r   <= '0;
			auth_r   <= 1'b0;
			hstart_r <= 1'b0;
			drive_r  <= 1'b0;
		end else if (ce) begin
			if (nv_write_done)
				ee_r <= W'(EEW_CYC);
			else if (ee_r != '0)
				ee_r <= ee_r - 1'b1;
			hstart_r <= chal_done;
			if (chal_done) begin
				auth_r <= 1'b0;
				hash_r <= W'(bt_r) - 1'b1;
			end else if (hash_r != '0)
				hash_r <= hash_r - 1'b1;
			else if (hstart_r || state_r == WSSQ_ACTIVE)
				auth_r <= auth_r | hstart_r | (hash_r == '0 && !sleeping);
			drive_r <= is_break;
		end
	end

	assign bus.dev_out       = 1'b0;
	assign bus.dev_oe        = drive_r;
	assign awake             = !sleeping;
	assign regulator_on      = !sleeping && state_r != WSSQ_POR;
	assign logic_rst_n       = regulator_on;
	assign dev_addr          = ctrl_r[`WSSQ_CFG_DAB_LO +: 2];
	assign bus_speed         = ctrl_r[`WSSQ_CFG_SPD_LO +: 2];
	assign bit_time          = bt_r;
	assign control_reg       = ctrl_r;
	assign status_reg        = stat_r;
	assign auto_sleep_enable = auto_sleep_enable_r;
	assign nv_busy           = (ee_r != '0);
	assign hash_start        = hstart_r;
	assign auth_ready        = auth_r && hash_r == '0;
endmodule : wssq_device

// ---- design/wssq_host.sv ----
`timescale 1ns/1ps
`include "wssq_defines.svh"
module wssq_host
	import wssq_pkg::*;
#(
	parameter int EEW_CYC = `WSSQ_EEW_CYC
)
(
	input  wire logic  clk,
	input  wire logic  rst_n,
	input  wire logic  ce,
	wssq_bus_if.host   bus,
	input  wire logic  wake_req,
	input  wire logic  nv_write_sent,
	output logic       wake_busy,
	output logic       ready_seen,
	output logic       may_send
);
	localparam int W = 24;
	localparam logic [W-1:0] BRK_C = W'(`WSSQ_HOST_BRK_CYC);

	logic [W-1:0] brk_r;
	logic [W-1:0] ee_r;
	logic         s1_r;
	logic         s2_r;
	logic         s3_r;
	logic         look_r;
	logic         seen_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			brk_r  <= '0;
			ee_r   <= '0;
			s1_r   <= 1'b1;
			s2_r   <= 1'b1;
			s3_r   <= 1'b1;
			look_r <= 1'b0;
			seen_r <= 1'b0;
		end else if (ce) begin
			s1_r <= bus.line;
			s2_r <= s1_r;
			s3_r <= s2_r;
			// Break above deglitch, below 60 us
			if (wake_req && brk_r == '0 && !look_r) begin
				brk_r  <= BRK_C;
				seen_r <= 1'b0;
			end else if (brk_r != '0)
				brk_r <= brk_r - 1'b1;
			// After release, a falling edge is the device's break
			if (brk_r == W'(1))
				look_r <= 1'b1;
			else if (look_r && s3_r && !s2_r) begin
				look_r <= 1'b0;
				seen_r <= 1'b1;
			end
			if (nv_write_sent)
				ee_r <= W'(EEW_CYC);
			else if (ee_r != '0)
				ee_r <= ee_r - 1'b1;
		end
	end

	assign bus.host_out = 1'b0;
	assign bus.host_oe  = (brk_r != '0);
	assign wake_busy    = (brk_r != '0) || look_r;
	assign ready_seen   = seen_r;
	assign may_send     = (ee_r == '0) && !wake_busy;
endmodule : wssq_host

// ---- testbench/wssq_assertions.sv ----
`timescale 1ns/1ps
module wssq_assertions #(
	parameter int BRK_MIN = 600,
	parameter int BRK_MAX = 604
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic dev_out,
	input wire logic dev_oe,
	input wire logic host_out,
	input wire logic host_oe,
	input wire logic line
);
	logic [15:0] since_r;
	logic [15:0] brk_cnt_r;
	logic [15:0] host_cnt_r;
	logic        pend_r;
	logic        woken_r;
	logic        host_d_r;
	wire         host_rise = host_oe && !host_d_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Pending flag covers only wakes; soft-reset answers are not timed here
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			since_r    <= 16'h0;
			brk_cnt_r  <= 16'h0;
			host_cnt_r <= 16'h0;
			pend_r     <= 1'b0;
			woken_r    <= 1'b0;
			host_d_r   <= 1'b0;
		end else begin
			host_d_r   <= host_oe;
			since_r    <= host_rise ? 16'h1 : since_r + 16'h1;
			brk_cnt_r  <= dev_oe ? brk_cnt_r + 16'h1 : 16'h0;
			host_cnt_r <= host_oe ? host_cnt_r + 16'h1 : 16'h0;
			woken_r    <= woken_r || host_rise;
			pend_r     <= host_rise || (pend_r && !dev_oe);
		end
	end

	sequence s_answer_start;
		$rose(dev_oe);
	endsequence
	sequence s_line_held;
		!line [*8];
	endsequence

	AST_DEV_ONLY_LOW: assert property (dev_oe |-> !dev_out)
		else $error("device drives the line high");
	AST_HOST_ONLY_LOW: assert property (host_oe |-> !host_out)
		else $error("host drives the line high");
	AST_BREAK_PULLS_LINE: assert property (s_answer_start |-> s_line_held)
		else $error("device break does not hold the line low");
	AST_ASLEEP_AT_POWER: assert property (!woken_r |-> !dev_oe)
		else $error("device answered before any wake break");
	AST_ANSWER_NOT_EARLY: assert property (pend_r && $rose(dev_oe) |->
		since_r >= 16'd1300)
		else $error("wake answer came too early");
	AST_ANSWER_NOT_LATE: assert property (pend_r |-> since_r <= 16'd2100)
		else $error("wake answer came too late");
	AST_BREAK_LEN: assert property ($fell(dev_oe) |->
		brk_cnt_r >= BRK_MIN)
		else $error("device break too short");
	AST_BREAK_NOT_LONG: assert property (dev_oe |-> brk_cnt_r <= BRK_MAX)
		else $error("device break too long");
	AST_HOST_BRK_WIDTH: assert property ($fell(host_oe) |->
		host_cnt_r > 16'd200 && host_cnt_r < 16'd600)
		else $error("host wake break width out of range");
endmodule : wssq_assertions

// ---- testbench/wake_sleep_power_sequencer_bench.sv ----
`timescale 1ns/1ps
`include "wssq_defines.svh"
module wake_sleep_power_sequencer_bench;
	import wssq_pkg::*;
	localparam int AUTO_SLEEP_ENABLE = 2000;
	localparam int EEW  = 100;
	localparam int BRK  = (`WSSQ_BRK_NUM * 433) / `WSSQ_BRK_DEN;
	logic          clk = 1'b0;
	logic          rst_n = 1'b0;
	logic          ce = 1'b1;
	wssq_byte_type mem [`WSSQ_MEM_BYTES];
	logic          sop_v = 1'b0, srst = 1'b0, nvw = 1'b0, chal = 1'b0;
	logic          aclr = 1'b0, aset = 1'b0, wreq = 1'b0, nvs = 1'b0;
	logic [1:0]    sop = 2'h0;
	logic          awake, reg_on, lrst_n, aen, busy, hstart, aready;
	logic          awake2, wbusy, rseen, msend;
	logic [1:0]    addr, spd;
	logic [15:0]   bt;
	wssq_byte_type ctl, sts;
	int            compares = 0;
	int            miscompares = 0;
	int            cyc = 0;

	wssq_bus_if bif ();
	wssq_bus_if bif2 ();
	wssq_device #(.AUTO_SLEEP_ENABLE_CYC(AUTO_SLEEP_ENABLE), .EEW_CYC(EEW)) wssq_device_i (
		.clk(clk), .rst_n(rst_n), .ce(ce), .bus(bif), .mem_data(mem),
		.sleep_op_valid(sop_v), .sleep_op(sop), .soft_reset(srst),
		.nv_write_done(nvw), .chal_done(chal), .auto_sleep_enable_clear(aclr),
		.auto_sleep_enable_set(aset), .awake(awake), .regulator_on(reg_on),
		.logic_rst_n(lrst_n), .dev_addr(addr), .bus_speed(spd),
		.bit_time(bt), .control_reg(ctl), .status_reg(sts),
		.auto_sleep_enable(aen), .nv_busy(busy), .hash_start(hstart),
		.auth_ready(aready));
	// Second device on its own wire, driven by hand to break host rules
	wssq_device #(.AUTO_SLEEP_ENABLE_CYC(AUTO_SLEEP_ENABLE), .EEW_CYC(EEW)) wssq_device_i2 (
		.clk(clk), .rst_n(rst_n), .ce(ce), .bus(bif2), .mem_data(mem),
		.sleep_op_valid(sop_v), .sleep_op(sop), .soft_reset(srst),
		.nv_write_done(nvw), .chal_done(chal), .auto_sleep_enable_clear(aclr),
		.auto_sleep_enable_set(aset), .awake(awake2), .regulator_on(),
		.logic_rst_n(), .dev_addr(), .bus_speed(), .bit_time(),
		.control_reg(), .status_reg(), .auto_sleep_enable(),
		.nv_busy(), .hash_start(), .auth_ready());
	wssq_host #(.EEW_CYC(EEW)) wssq_host_i (
		.clk(clk), .rst_n(rst_n), .ce(ce), .bus(bif), .wake_req(wreq),
		.nv_write_sent(nvs), .wake_busy(wbusy), .ready_seen(rseen),
		.may_send(msend));
	wssq_assertions #(.BRK_MIN(BRK - 2), .BRK_MAX(BRK + 2))
		wssq_assertions_i (.clk(clk), .rst_n(rst_n),
		.dev_out(bif.dev_out), .dev_oe(bif.dev_oe),
		.host_out(bif.host_out), .host_oe(bif.host_oe), .line(bif.line));

	always #50 clk = ~clk;

	task automatic finish_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test

	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			miscompares++;
			finish_test();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#10;
	endtask : tick

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask : pulse

	task automatic wait_hi(ref logic s, input int lim, output int n);
		n = 0;
		while (s !== 1'b1 && n < lim) begin
			tick(1);
			n++;
		end
	endtask : wait_hi

	task automatic t_glitch;
		bif2.host_oe = 1'b1;
		tick(60);
		bif2.host_oe = 1'b0;
		tick(300);
		chk(awake2, 1'b0);
		bif2.host_oe = 1'b1;
		tick(1000);
		bif2.host_oe = 1'b0;
		tick(1500);
		chk(awake2, 1'b1);
		// Short break while awake: no new power-on sequence
		bif2.host_oe = 1'b1;
		tick(300);
		bif2.host_oe = 1'b0;
		tick(1700);
		chk({awake2, bif2.dev_oe}, 2'h2);
	endtask : t_glitch

	task automatic t_wake;
		int n;
		pulse(wreq);
		tick(150);
		chk({awake, reg_on, lrst_n}, 3'h4);
		wait_hi(bif.dev_oe, 3000, n);
		chk(n + 150 >= 1300 && n + 150 <= 2100, 1);
		tick(700);
		chk({awake, reg_on, lrst_n, rseen, wbusy}, 5'h1e);
		chk({addr, spd, aen}, 5'h17);
		chk(bt, `WSSQ_BT_SPD3);
		chk({ctl, sts}, 16'hbcbc);
	endtask : t_wake

	task automatic t_auth_nvw;
		int n;
		pulse(chal);
		wait_hi(hstart, 4, n);
		chk(n < 2, 1);
		chk(aready, 1'b0);
		wait_hi(aready, 433, n);
		chk(aready, 1'b1);
		nvs = 1'b1;
		pulse(nvw);
		nvs = 1'b0;
		tick(EEW - 5);
		chk({busy, msend}, 2'h2);
		tick(10);
		chk({busy, msend}, 2'h1);
	endtask : t_auth_nvw

	task automatic t_srst;
		int n;
		pulse(aclr);
		chk(aen, 1'b0);
		pulse(srst);
		wait_hi(bif.dev_oe, 300, n);
		chk(bif.dev_oe, 1'b1);
		chk(aen, 1'b1);
		tick(700 + AUTO_SLEEP_ENABLE - 800);
		chk(awake, 1'b1);
		tick(900);
		chk({awake, reg_on}, 2'h0);
	endtask : t_srst

	task automatic t_sleep_op;
		sop = 2'h1;
		pulse(sop_v);
		tick(100);
		chk(awake, 1'b1);
		sop = 2'h3;
		pulse(sop_v);
		tick(30);
		chk(reg_on, 1'b1);
		tick(100);
		chk({awake, reg_on}, 2'h0);
	endtask : t_sleep_op

	initial begin
		for (int i = 0; i < `WSSQ_MEM_BYTES; i++) begin
			mem[i] = 8'(i * 17);
		end
		// Address 2, speed code 3, auto-sleep on, no lock-out
		mem[0] = 8'hbc;
		bif2.host_out = 1'b0;
		bif2.host_oe = 1'b0;
		repeat (10) @(posedge clk);
		#10;
		rst_n = 1'b1;
		tick(500);
		chk({awake, bif.dev_oe}, 2'h0);
		t_glitch();
		t_wake();
		t_auth_nvw();
		pulse(aclr);
		tick(AUTO_SLEEP_ENABLE + 100);
		chk({aen, awake}, 2'h1);
		pulse(aset);
		tick(AUTO_SLEEP_ENABLE + 100);
		chk({aen, awake}, 2'h2);
		t_wake();
		t_srst();
		t_wake();
		t_sleep_op();
		finish_test();
	end
endmodule : wake_sleep_power_sequencer_bench
